// ===== hdl/pcstack_pkg.sv
// Constants for the program counter and return stack block.
// Assumes one core clock; the sequencer drives one-cycle command pulses.
`default_nettype none
package pcstack_pkg;
  localparam int PC_W = 21;
  localparam int DEPTH = 31;
  localparam int PTR_W = 5;
  localparam logic [20:0] RESET_VECTOR = 21'h000000;
  localparam logic [20:0] HIGH_VECTOR = 21'h000008;
  localparam logic [20:0] LOW_VECTOR = 21'h000018;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [4:0] PTR_MAX = 5'h1F;
  localparam logic [4:0] PTR_ZERO = 5'h00;
  // Implemented program memory, in bytes
  localparam logic [20:0] MEM_BYTES_DEF = 21'h008000;
  localparam int CFG_WORDS = 4;
  localparam int CFG_BYTES = 8;
  localparam logic [20:0] CFG_SPAN = 21'h000008;
  // Stack pointer register layout
  localparam int SP_FULL_BIT = 7;
  localparam int SP_UNF_BIT = 6;
  localparam logic [7:0] SP_RESET = 8'h00;
  // Register offsets
  localparam logic [3:0] REG_LOW_BYTE = 4'h0;
  localparam logic [3:0] REG_LATH = 4'h1;
  localparam logic [3:0] REG_LATU = 4'h2;
  localparam logic [3:0] REG_TOP_LOW = 4'h3;
  localparam logic [3:0] REG_TOP_HIGH = 4'h4;
  localparam logic [3:0] REG_TOP_UPPER = 4'h5;
  localparam logic [3:0] REG_SPTR = 4'h6;
  localparam logic [3:0] REG_CFG0 = 4'h8;
  // Sequencer commands
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_STEP = 4'h1,
    CMD_JUMP = 4'h2,
    CMD_CALL = 4'h3,
    CMD_RET = 4'h4,
    CMD_IRQ_HI = 4'h5,
    CMD_IRQ_LO = 4'h6,
    CMD_PUSH = 4'h7,
    CMD_POP = 4'h8
  } cmd_e;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_CFG = 2'b01,
    ST_RUN = 2'b10
  } state_e;
endpackage : pcstack_pkg
`default_nettype wire

// ===== hdl/fetch_guard.sv
// Program memory fetch guard: zero data above implemented memory.
// Assumes memory data is valid in the same cycle as the address.
`default_nettype none
module fetch_guard
  import pcstack_pkg::*;
#(
  parameter logic [20:0] MEM_BYTES = MEM_BYTES_DEF
)
(
  // Address and raw data
  input wire logic [20:0] i_addr,
  input wire logic [15:0] i_raw,
  // Guarded data
  output logic [15:0] o_data
);
  wire in_range = i_addr < MEM_BYTES;
  assign o_data = in_range ? i_raw : 16'h0000;
endmodule : fetch_guard
`default_nettype wire

// ===== hdl/pc_return_stack.sv
// Program counter, latches, return stack, config copy at reset.
// Assumes a sequencer giving one command per cycle and a plain register port.
//
// Added by the designer: the register addresses and the plain strobed port.
`default_nettype none
module pc_return_stack
  import pcstack_pkg::*;
#(
  parameter logic [20:0] MEM_BYTES = MEM_BYTES_DEF
)
(
  // Clock and resets
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_por,
  // Sequencer
  input wire logic [3:0] i_cmd,
  input wire logic [20:0] i_target,
  // Program memory
  input wire logic [15:0] i_mem_data,
  output logic [20:0] o_pc,
  output logic [15:0] o_fetch_data,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Status
  output logic [7:0] o_cfg_lo,
  output logic o_cfg_done,
  output logic o_stack_reset
);
  // Odd or tiny memories would misalign the configuration fetch
  if (MEM_BYTES < CFG_SPAN || MEM_BYTES[0])
  begin : g_mem_check
    $error("MEM_BYTES must be even and hold the configuration words");
  end

  state_e state_q, state_d;
  logic [20:0] pc_q, pc_d, fetch_addr;
  logic [7:0] lath_q, latu_q;
  logic [4:0] ptr_q;
  logic full_q, unf_q;
  logic [20:0] stack_q [1:DEPTH];
  logic [7:0] cfg_q [0:CFG_BYTES-1];
  logic [2:0] cfg_idx_q;
  logic [7:0] rdata_q, fdata_lo;
  logic cfg_done_q, ovf_rst_q;
  logic [15:0] guarded;

  function automatic logic [20:0] align(input logic [20:0] v);
    align = {v[20:1], 1'b0};
  endfunction : align

  wire run = (state_q == ST_RUN);
  wire cmd_call = run && (i_cmd == CMD_CALL);
  wire cmd_irq = run && (i_cmd == CMD_IRQ_HI || i_cmd == CMD_IRQ_LO);
  wire cmd_spush = run && (i_cmd == CMD_PUSH);
  wire cmd_pushing = cmd_call || cmd_irq || cmd_spush;
  wire cmd_ret = run && (i_cmd == CMD_RET);
  wire cmd_spop = run && (i_cmd == CMD_POP);
  wire wr_low_byte = run && i_wr && i_addr == REG_LOW_BYTE;
  wire rd_low_byte = run && i_rd && i_addr == REG_LOW_BYTE;
  wire wr_sp = run && i_wr && i_addr == REG_SPTR;
  wire [4:0] ptr_inc = ptr_q + 5'h01;
  wire top_valid = ptr_q != PTR_ZERO;
  // Overflow-reset bit sits in bit 0 of the fourth word low byte
  wire ovf_rst_en = cfg_q[6][0];
  wire push_last = cmd_pushing && ptr_q == PTR_MAX - 5'h01;
  wire push_stuck = cmd_pushing && ptr_q == PTR_MAX;
  wire pop_under = (cmd_ret || cmd_spop) && !top_valid;
  wire [20:0] push_val = (push_last && ovf_rst_en) ? pc_q + PC_STEP : pc_q;
  wire stack_rst = push_last && ovf_rst_en;

  // The copy walks the counter itself, so memory sees the address on o_pc
  wire [20:0] cfg_base = MEM_BYTES - CFG_SPAN;
  assign fetch_addr = pc_q;

  fetch_guard #(.MEM_BYTES(MEM_BYTES)) u_guard (
    .i_addr(fetch_addr),
    .i_raw(i_mem_data),
    .o_data(guarded)
  );
  assign fdata_lo = guarded[7:0];

  // Next state: configuration copy runs once per reset
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_RESET: state_d = ST_CFG;
      ST_CFG: if (cfg_idx_q == 3'h6) state_d = ST_RUN;
      ST_RUN: state_d = ST_RUN;
      default: state_d = ST_RESET;
    endcase
  end

  // Counter next value; the overflow reset returns to the reset vector
  always_comb
  begin
    pc_d = pc_q;
    if (state_q == ST_RESET)
      pc_d = cfg_base;
    else if (state_q == ST_CFG)
      pc_d = (cfg_idx_q == 3'h6) ? RESET_VECTOR : cfg_base + {18'h00000, cfg_idx_q + 3'h2};
    else if (stack_rst)
      pc_d = RESET_VECTOR;
    else if (wr_low_byte)
      pc_d = align({latu_q[4:0], lath_q, i_wdata});
    else if (run)
    begin
      case (cmd_e'(i_cmd))
        CMD_STEP: pc_d = align(pc_q + PC_STEP);
        CMD_JUMP: pc_d = align(i_target);
        CMD_CALL: pc_d = align(i_target);
        CMD_IRQ_HI: pc_d = HIGH_VECTOR;
        CMD_IRQ_LO: pc_d = LOW_VECTOR;
        CMD_RET: pc_d = top_valid ? stack_q[ptr_q] : RESET_VECTOR;
        default: pc_d = pc_q;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      state_q <= ST_RESET;
      pc_q <= RESET_VECTOR;
      ptr_q <= PTR_ZERO;
      cfg_idx_q <= 3'h0;
      cfg_done_q <= 1'b0;
    end
    else
    begin
      state_q <= stack_rst ? ST_RESET : state_d;
      pc_q <= pc_d;
      cfg_idx_q <= (state_q == ST_CFG) ? cfg_idx_q + 3'h2 : 3'h0;
      cfg_done_q <= stack_rst ? 1'b0 : (state_d == ST_RUN);
      if (stack_rst)
        ptr_q <= PTR_ZERO;
      else if (wr_sp)
        ptr_q <= i_wdata[4:0];
      else if (cmd_pushing && !push_stuck)
        ptr_q <= ptr_inc;
      else if ((cmd_ret || cmd_spop) && top_valid)
        ptr_q <= ptr_q - 5'h01;
    end
  end

  // Stack storage; entry zero does not exist
  always_ff @(posedge i_ref_clk)
  begin
    if (cmd_pushing && !push_stuck)
      stack_q[ptr_inc] <= push_val;
    else if (run && i_wr && top_valid && i_addr == REG_TOP_LOW)
      stack_q[ptr_q][7:0] <= i_wdata;
    else if (run && i_wr && top_valid && i_addr == REG_TOP_HIGH)
      stack_q[ptr_q][15:8] <= i_wdata;
    else if (run && i_wr && top_valid && i_addr == REG_TOP_UPPER)
      stack_q[ptr_q][20:16] <= i_wdata[4:0];
  end

  // Config copy: word pairs into ascending bytes, low byte first
  always_ff @(posedge i_ref_clk)
  begin
    if (state_q == ST_CFG)
    begin
      cfg_q[cfg_idx_q] <= fdata_lo;
      cfg_q[cfg_idx_q + 3'h1] <= guarded[15:8];
    end
  end

  // Flags clear only by power-on or software; a set wins over the software clear, power-on wins over a set
  always_ff @(posedge i_ref_clk)
  begin
    if (i_por)
    begin
      full_q <= 1'b0;
      unf_q <= 1'b0;
    end
    else
    begin
      if (push_last || push_stuck)
        full_q <= 1'b1;
      else if (wr_sp && !i_wdata[SP_FULL_BIT])
        full_q <= 1'b0;
      if (pop_under)
        unf_q <= 1'b1;
      else if (wr_sp && !i_wdata[SP_UNF_BIT])
        unf_q <= 1'b0;
    end
  end

  // Latches: a low byte read copies upper bytes; calls and returns leave them
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      lath_q <= 8'h00;
      latu_q <= 8'h00;
      rdata_q <= 8'h00;
      ovf_rst_q <= 1'b0;
    end
    else
    begin
      ovf_rst_q <= stack_rst;
      if (rd_low_byte)
      begin
        lath_q <= pc_q[15:8];
        latu_q <= {3'b000, pc_q[20:16]};
      end
      else if (run && i_wr && i_addr == REG_LATH)
        lath_q <= i_wdata;
      else if (run && i_wr && i_addr == REG_LATU)
        latu_q <= {3'b000, i_wdata[4:0]};
      if (i_rd)
      begin
        case (i_addr)
          REG_LOW_BYTE: rdata_q <= pc_q[7:0];
          REG_LATH: rdata_q <= lath_q;
          REG_LATU: rdata_q <= latu_q;
          REG_TOP_LOW: rdata_q <= top_valid ? stack_q[ptr_q][7:0] : 8'h00;
          REG_TOP_HIGH: rdata_q <= top_valid ? stack_q[ptr_q][15:8] : 8'h00;
          REG_TOP_UPPER: rdata_q <= top_valid ? {3'b000, stack_q[ptr_q][20:16]} : 8'h00;
          REG_SPTR: rdata_q <= {full_q, unf_q, 1'b0, ptr_q};
          default: rdata_q <= (i_addr >= REG_CFG0 && i_addr < REG_CFG0 + 4'h6) ? cfg_q[i_addr[2:0]] : 8'h00;
        endcase
      end
      else
        rdata_q <= 8'h00;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    o_fetch_data <= i_reset_n ? guarded : 16'h0000;
  end

  assign o_pc = pc_q;
  assign o_rdata = rdata_q;
  assign o_cfg_lo = cfg_q[0];
  assign o_cfg_done = cfg_done_q;
  assign o_stack_reset = ovf_rst_q;

  property p_step;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (cmd_spush == 1'b0 && run && i_cmd == CMD_STEP && !wr_low_byte) |=> pc_q == $past(pc_q) + PC_STEP;
  endproperty
  a_step: assert property (p_step) else $error("step not by two");
  property p_align;
    @(posedge i_ref_clk) disable iff (!i_reset_n) pc_q[0] == 1'b0;
  endproperty
  a_align: assert property (p_align) else $error("counter misaligned");
  property p_hi;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (cmd_irq && i_cmd == CMD_IRQ_HI && !stack_rst && !wr_low_byte) |=> pc_q == HIGH_VECTOR;
  endproperty
  a_hi: assert property (p_hi) else $error("bad high vector");
  property p_push;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (cmd_pushing && !push_stuck && !stack_rst && !wr_sp) |=> ptr_q == $past(ptr_q) + 5'h01;
  endproperty
  a_push: assert property (p_push) else $error("push did not increment");
  property p_under;
    @(posedge i_ref_clk) disable iff (!i_reset_n || i_por)
    (cmd_ret && !top_valid && !wr_low_byte && !wr_sp) |=> pc_q == RESET_VECTOR && unf_q && ptr_q == PTR_ZERO;
  endproperty
  a_under: assert property (p_under) else $error("underflow handling wrong");
  property p_stuck;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (push_stuck && !wr_sp) |=> ptr_q == PTR_MAX;
  endproperty
  a_stuck: assert property (p_stuck) else $error("pointer left 31");
  property p_ovf;
    @(posedge i_ref_clk) disable iff (!i_reset_n || i_por)
    stack_rst |=> ptr_q == PTR_ZERO && full_q && pc_q == RESET_VECTOR && o_stack_reset;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow reset wrong");
  property p_latch;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    rd_low_byte |=> lath_q == $past(pc_q[15:8]);
  endproperty
  a_latch: assert property (p_latch) else $error("latch not loaded");
  property p_reset;
    @(posedge i_ref_clk) !i_reset_n |=> pc_q == RESET_VECTOR && ptr_q == PTR_ZERO;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  c_call: cover property (@(posedge i_ref_clk) cmd_call);
  c_ovf: cover property (@(posedge i_ref_clk) stack_rst);
  c_under: cover property (@(posedge i_ref_clk) pop_under);
endmodule : pc_return_stack
`default_nettype wire

// ===== tb/prog_mem_model.sv
// Program memory model: ramp words below, configuration words at the top.
// Assumes a combinational read of the word at the byte address.
`default_nettype none
module prog_mem_model #(
  parameter logic [20:0] MEM_BYTES = 21'h000100
)
(
  // Fetch side
  input wire logic [20:0] i_addr,
  input wire logic i_ovf_reset_en,
  // Word out
  output logic [15:0] o_data
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic above;
  wire logic in_cfg;
  wire logic [15:0] cfg_word;
  assign above = i_addr >= MEM_BYTES;
  assign in_cfg = i_addr >= (MEM_BYTES - 21'h000008);
  // Byte n reads C0h+n; byte 6 carries the overflow reset enable
  assign cfg_word = (i_addr[2:1] == 2'h3) ? {8'hC7, 7'h00, i_ovf_reset_en} :
    {5'h18, i_addr[2:1], 1'b1, 5'h18, i_addr[2:1], 1'b0};
  // Junk above memory so a zero from the guard means something
  assign o_data = above ? ~i_addr[15:0] : (in_cfg ? cfg_word : i_addr[16:1]);
endmodule : prog_mem_model
`default_nettype wire

// ===== tb/program_counter_return_stack_test.sv
// Self-checking bench for the program counter and return stack.
// Assumes the memory model answers combinationally at the counter.
`default_nettype none
module program_counter_return_stack_test;
  import pcstack_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [20:0] MEM = 21'h000100;
  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_por = 1'b1;
  logic [3:0] i_cmd = 4'h0;
  logic [20:0] i_target = 21'h000000;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic ovf_en = 1'b1;
  wire logic [20:0] o_pc;
  wire logic [15:0] mem_data;
  wire logic [15:0] o_fetch_data;
  wire logic [7:0] o_rdata;
  wire logic [7:0] o_cfg_lo;
  wire logic o_cfg_done;
  wire logic o_stack_reset;
  int fail_count = 0;
  int samples_checked = 0;
  int stack_resets = 0;
  int i;
  int j;

  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) if (o_stack_reset === 1'b1) stack_resets++;

  pc_return_stack #(.MEM_BYTES(MEM)) dut_u (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_por(i_por),
    .i_cmd(i_cmd), .i_target(i_target), .i_mem_data(mem_data), .o_pc(o_pc), .o_fetch_data(o_fetch_data),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_cfg_lo(o_cfg_lo), .o_cfg_done(o_cfg_done), .o_stack_reset(o_stack_reset));
  prog_mem_model #(.MEM_BYTES(MEM)) mem_u (.i_addr(o_pc), .i_ovf_reset_en(ovf_en), .o_data(mem_data));

  task automatic chk(input string name, input logic [20:0] exp, input logic [20:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic cmd(input logic [3:0] c, input logic [20:0] t);
    @(posedge i_ref_clk);
    i_cmd <= c;
    i_target <= t;
    @(posedge i_ref_clk);
    i_cmd <= CMD_NONE;
    @(negedge i_ref_clk);
  endtask : cmd

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    @(negedge i_ref_clk);
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string name);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(negedge i_ref_clk);
    chk(name, 21'(exp), 21'(o_rdata));
  endtask : rdc

  task automatic wait_done();
    i = 0;
    while (o_cfg_done !== 1'b1 && i < 40)
    begin
      @(negedge i_ref_clk);
      i++;
    end
    chk("cfg_done", 21'h000001, 21'(o_cfg_done));
  endtask : wait_done

  task automatic reset(input logic por);
    @(posedge i_ref_clk);
    i_reset_n <= 1'b0;
    i_por <= por;
    repeat (4) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    i_por <= 1'b0;
    @(negedge i_ref_clk);
    wait_done();
  endtask : reset

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    #100000;
    fail_count++;
    tally_and_finish();
  end

  // Top entry accesses run with no interrupt command in flight
  initial
  begin
    reset(1'b1);
    chk("pc", RESET_VECTOR, o_pc);
    rdc(REG_SPTR, 8'h00, "sptr");
    chk("cfg_lo", 21'h0000C0, 21'(o_cfg_lo));
    rdc(REG_CFG0 + 4'h5, 8'hC5, "cfg5");
    cmd(CMD_STEP, 21'h000000);
    chk("pc", 21'h000002, o_pc);
    cmd(CMD_JUMP, 21'h1FFFFF);
    chk("pc", 21'h1FFFFE, o_pc);
    cmd(CMD_JUMP, 21'h000040);
    @(negedge i_ref_clk);
    chk("fetch", 21'h000020, 21'(o_fetch_data));
    cmd(CMD_JUMP, 21'h000200);
    @(negedge i_ref_clk);
    chk("fetch", 21'h000000, 21'(o_fetch_data));
    wr(REG_LATH, 8'h12);
    wr(REG_LATU, 8'h03);
    wr(REG_LOW_BYTE, 8'h57);
    chk("pc", 21'h031256, o_pc);
    cmd(CMD_JUMP, 21'h0A5432);
    rdc(REG_LOW_BYTE, 8'h32, "counter_low_byte");
    rdc(REG_LATH, 8'h54, "lath");
    rdc(REG_LATU, 8'h0A, "latu");
    cmd(CMD_CALL, 21'h000100);
    chk("pc", 21'h000100, o_pc);
    rdc(REG_SPTR, 8'h01, "sptr");
    rdc(REG_TOP_LOW, 8'h32, "top_entry_low");
    rdc(REG_TOP_HIGH, 8'h54, "top_entry_high");
    rdc(REG_TOP_UPPER, 8'h0A, "top_entry_upper");
    rdc(REG_LATH, 8'h54, "lath");
    cmd(CMD_IRQ_HI, 21'h000000);
    chk("pc", HIGH_VECTOR, o_pc);
    cmd(CMD_IRQ_LO, 21'h000000);
    chk("pc", LOW_VECTOR, o_pc);
    rdc(REG_SPTR, 8'h03, "sptr");
    rdc(REG_TOP_LOW, 8'h08, "top_entry_low");
    cmd(CMD_RET, 21'h000000);
    chk("pc", 21'h000008, o_pc);
    cmd(CMD_RET, 21'h000000);
    chk("pc", 21'h000100, o_pc);
    cmd(CMD_RET, 21'h000000);
    chk("pc", 21'h0A5432, o_pc);
    cmd(CMD_RET, 21'h000000);
    chk("pc", 21'h000000, o_pc);
    rdc(REG_SPTR, 8'h40, "sptr");
    wr(REG_SPTR, 8'h00);
    rdc(REG_SPTR, 8'h00, "sptr");
    cmd(CMD_JUMP, 21'h000456);
    cmd(CMD_PUSH, 21'h000000);
    rdc(REG_TOP_LOW, 8'h56, "top_entry_low");
    wr(REG_TOP_LOW, 8'h78);
    wr(REG_TOP_HIGH, 8'h09);
    wr(REG_TOP_UPPER, 8'h01);
    rdc(REG_TOP_HIGH, 8'h09, "top_entry_high");
    cmd(CMD_PUSH, 21'h000000);
    cmd(CMD_POP, 21'h000000);
    rdc(REG_SPTR, 8'h01, "sptr");
    cmd(CMD_RET, 21'h000000);
    chk("pc", 21'h010978, o_pc);
    // Overflow with the reset disabled: pointer sticks at the top
    ovf_en <= 1'b0;
    reset(1'b1);
    for (j = 0; j < 31; j++) cmd(CMD_CALL, 21'h000200);
    rdc(REG_SPTR, 8'h9F, "sptr");
    cmd(CMD_JUMP, 21'h000300);
    cmd(CMD_CALL, 21'h000400);
    rdc(REG_SPTR, 8'h9F, "sptr");
    rdc(REG_TOP_HIGH, 8'h02, "top_entry_high");
    chk("stack_resets", 21'h000000, 21'(stack_resets));
    // Overflow with the reset enabled
    ovf_en <= 1'b1;
    reset(1'b1);
    for (j = 0; j < 31; j++) cmd(CMD_CALL, 21'h000200);
    for (j = 0; j < 10 && stack_resets == 0; j++) @(negedge i_ref_clk);
    wait_done();
    chk("stack_resets", 21'h000001, 21'(stack_resets));
    chk("pc", RESET_VECTOR, o_pc);
    rdc(REG_SPTR, 8'h80, "sptr");
    wr(REG_SPTR, 8'h9F);
    rdc(REG_TOP_LOW, 8'h02, "top_entry_low");
    rdc(REG_TOP_HIGH, 8'h02, "top_entry_high");
    reset(1'b0);
    rdc(REG_SPTR, 8'h80, "sptr");
    reset(1'b1);
    rdc(REG_SPTR, 8'h00, "sptr");
    tally_and_finish();
  end
endmodule : program_counter_return_stack_test
`default_nettype wire
